// >>> hw/oscc_top.v
// Output state and configuration controller for one supply channel.
// Assumes an AHB-Lite master on sys_clk and a nonvolatile store modelled as shadow words.
//
// Local design decisions: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "oscc_defines.vh"
module oscc_top #(
  parameter RATED_FS = 16'hffff, // Full-scale channel rating code.
  parameter VOLT_HARD = 16'hf000 // Hard current limit for the hard-limit error.
) (
  input wire sys_clk,
  input wire rst_n,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire [15:0] meas_main, // Measured main channel, from a pin domain.
  input wire [15:0] meas_curr, // Measured current, from a pin domain.
  input wire at_curr_limit, // Current limit engaged, from a pin domain.
  output reg output_on,
  output reg volt_mode,
  output reg [15:0] volt_setpoint,
  output reg [15:0] curr_setpoint,
  output reg [15:0] volt_limit_dac,
  output reg [15:0] curr_limit_dac,
  output reg [3:0] questionable,
  output reg device_error,
  output reg status_clear,
  output reg tx_valid,
  output reg [7:0] tx_data
);

  // Maximum limit code, computed once from the rating at full integer width so that
  // no product bits are dropped before the saturation test.
  localparam [31:0] MAX_WIDE = (RATED_FS * `OSCC_PCT_MAX) / `OSCC_PCT_BASE;
  localparam [15:0] MAX_LIMIT = (MAX_WIDE > 32'h0000ffff) ? 16'hffff : MAX_WIDE[15:0];

  // Bus is always ready and always answers OKAY; no wait states are added.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Address phase capture.
  reg dp_write;
  reg dp_read;
  reg [11:0] dp_addr;
  // A transfer is taken only while the bus is ready, although this slave never stalls.
  wire ap_valid = hsel & hready & htrans[1];

  // Two-stage synchronisers for the pin inputs.
  reg [15:0] meas_s1, meas_s2, curr_s1, curr_s2;
  reg lim_s1, lim_s2;

  // Volatile configuration.
  reg [3:0] off_limit_select;
  reg [15:0] off_state_limit_value_v; // Programmed voltage off-state limit.
  reg [15:0] off_state_limit_value_i; // Programmed current off-state limit.
  reg [15:0] tolerance_window_setting;
  reg [7:0] error_response_config;
  reg [2:0] flags; // Line-feed, device-clear, reset-output.
  reg [15:0] system_settings_cmd;
  reg [15:0] ref_target; // Value the window compares against.

  // Nonvolatile shadow words and staged system settings.
  reg [15:0] nvm_window;
  reg [31:0] nvm_iface; // sel, flags, off value v.
  reg [15:0] nvm_iface_i;
  reg [15:0] nvm_sysset;
  reg [15:0] staged_sysset;
  reg loaded; // Power-up load done.

  // Output-buffer model for read replies.
  reg obuf_full;

  // Pending command pulse decoded from a write.
  reg [3:0] cmd;

  // Decode whether a word write hits a given offset.
  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // Selected limit value for one channel while the output is off.
  function [15:0] off_limit;
    input use_max;
    input use_prog;
    input [15:0] prog;
    begin
      if (use_max) begin
        off_limit = MAX_LIMIT;
      end else if (use_prog) begin
        off_limit = prog;
      end else begin
        off_limit = 16'h0000;
      end
    end
  endfunction

  // Synchronise pin inputs before any logic reads them.
  // Each bit is synchronised on its own, so a word that moves during a sample may tear for one
  // cycle; measured channels move slowly next to sys_clk, which makes that acceptable here.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meas_s1 <= 16'h0000;
      meas_s2 <= 16'h0000;
      curr_s1 <= 16'h0000;
      curr_s2 <= 16'h0000;
      lim_s1 <= 1'b0;
      lim_s2 <= 1'b0;
    end else begin
      meas_s1 <= meas_main;
      meas_s2 <= meas_s1;
      curr_s1 <= meas_curr;
      curr_s2 <= curr_s1;
      lim_s1 <= at_curr_limit;
      lim_s2 <= lim_s1;
    end
  end

  // Data-phase bookkeeping for the bus.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_write <= 1'b0;
      dp_read <= 1'b0;
      dp_addr <= 12'h000;
    end else begin
      dp_write <= ap_valid & hwrite;
      dp_read <= ap_valid & ~hwrite;
      dp_addr <= {haddr[11:2], 2'b00};
    end
  end

  // Window distance and error conditions.
  wire [15:0] diff = (meas_s2 > ref_target) ? (meas_s2 - ref_target) : (ref_target - meas_s2);
  wire out_window = output_on & (diff > tolerance_window_setting);
  wire curr_hard = output_on & (curr_s2 > VOLT_HARD);
  wire err_win = out_window & error_response_config[`OSCC_ERR_WIN];
  wire err_lim = output_on & lim_s2 & error_response_config[`OSCC_ERR_LIM];
  wire err_hard = curr_hard & error_response_config[`OSCC_ERR_HARD];
  wire err_any = err_win | err_lim | err_hard;
  wire err_shut = err_any & error_response_config[`OSCC_ERR_SHUT];

  // Command register writes decoded as one-cycle commands.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd <= `OSCC_CMD_NONE;
    end else if (dp_write && hit(dp_addr, `OSCC_REG_CMD)) begin
      cmd <= hwdata[3:0];
    end else begin
      cmd <= `OSCC_CMD_NONE;
    end
  end

  // Reset-like action shared by reset and, when enabled, device clear.
  wire do_reset = (cmd == `OSCC_CMD_RST) | ((cmd == `OSCC_CMD_DCLR) & flags[`OSCC_FLG_DC]);

  // Configuration registers, nonvolatile commits and the power-up load.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      off_limit_select <= `OSCC_SEL_DEFAULT;
      off_state_limit_value_v <= 16'h0000;
      off_state_limit_value_i <= 16'h0000;
      tolerance_window_setting <= `OSCC_WINDOW_DEFAULT;
      error_response_config <= 8'h00;
      flags <= `OSCC_FLAGS_DEFAULT;
      system_settings_cmd <= 16'h0000;
      nvm_window <= `OSCC_WINDOW_DEFAULT;
      nvm_iface <= 32'h00000000;
      nvm_iface_i <= 16'h0000;
      nvm_sysset <= 16'h0000;
      staged_sysset <= 16'h0000;
      loaded <= 1'b0;
    end else if (!loaded) begin
      // First cycle after release copies the nonvolatile words into volatile state.
      loaded <= 1'b1;
      tolerance_window_setting <= nvm_window;
      off_limit_select <= nvm_iface[3:0];
      flags <= nvm_iface[6:4];
      off_state_limit_value_v <= nvm_iface[31:16];
      off_state_limit_value_i <= nvm_iface_i;
      system_settings_cmd <= nvm_sysset;
    end else begin
      // Register writes touch only volatile copies until an update command.
      if (dp_write && hit(dp_addr, `OSCC_REG_OFFSEL)) begin
        off_limit_select <= hwdata[3:0];
      end
      if (dp_write && hit(dp_addr, `OSCC_REG_OFFVAL)) begin
        off_state_limit_value_v <= hwdata[15:0];
        off_state_limit_value_i <= hwdata[31:16];
      end
      if (dp_write && hit(dp_addr, `OSCC_REG_WINDOW)) begin
        tolerance_window_setting <= hwdata[15:0];
      end
      if (dp_write && hit(dp_addr, `OSCC_REG_ERRCFG)) begin
        error_response_config <= hwdata[7:0];
      end
      if (dp_write && hit(dp_addr, `OSCC_REG_FLAGS)) begin
        flags <= hwdata[2:0];
      end
      if (dp_write && hit(dp_addr, `OSCC_REG_SYSSET)) begin
        system_settings_cmd <= hwdata[15:0];
      end
      case (cmd)
        `OSCC_CMD_UPD_SHUT: begin
          nvm_window <= tolerance_window_setting;
        end
        `OSCC_CMD_UPD_IF: begin
          nvm_iface <= {off_state_limit_value_v, 9'h000, flags, off_limit_select};
          nvm_iface_i <= off_state_limit_value_i;
          nvm_sysset <= staged_sysset;
        end
        `OSCC_CMD_STAGE: begin
          staged_sysset <= system_settings_cmd;
        end
        `OSCC_CMD_FACTORY: begin
          off_limit_select <= `OSCC_SEL_DEFAULT;
          off_state_limit_value_v <= 16'h0000;
          off_state_limit_value_i <= 16'h0000;
          tolerance_window_setting <= `OSCC_WINDOW_DEFAULT;
          error_response_config <= 8'h00;
          flags <= `OSCC_FLAGS_DEFAULT;
          system_settings_cmd <= 16'h0000;
          staged_sysset <= 16'h0000;
          nvm_window <= `OSCC_WINDOW_DEFAULT;
          nvm_iface <= 32'h00000000;
          nvm_iface_i <= 16'h0000;
          nvm_sysset <= 16'h0000;
        end
        default: begin
        end
      endcase
    end
  end

  // Output state, setpoints and status actions.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      output_on <= 1'b0;
      volt_mode <= 1'b1;
      volt_setpoint <= 16'h0000;
      curr_setpoint <= 16'h0000;
      ref_target <= 16'h0000;
      status_clear <= 1'b0;
    end else begin
      status_clear <= (cmd == `OSCC_CMD_DCLR);
      if (dp_write && hit(dp_addr, `OSCC_REG_SETPT)) begin
        // Setpoints are taken at any time; the limit channels use them only while the output is on.
        volt_setpoint <= hwdata[15:0];
        curr_setpoint <= hwdata[31:16];
        ref_target <= volt_mode ? hwdata[15:0] : hwdata[31:16];
      end
      if (dp_write && hit(dp_addr, `OSCC_REG_CTRL)) begin
        volt_mode <= hwdata[0];
      end
      if (do_reset) begin
        volt_setpoint <= 16'h0000;
        curr_setpoint <= 16'h0000;
        ref_target <= 16'h0000;
        volt_mode <= 1'b1;
        output_on <= flags[`OSCC_FLG_RO];
      end else if (cmd == `OSCC_CMD_OUT_ON) begin
        output_on <= 1'b1;
      end else if (cmd == `OSCC_CMD_OUT_OFF || err_shut) begin
        output_on <= 1'b0;
      end
    end
  end

  // Limit channels follow the selection whenever the output is off, so a new
  // selection lands at once while off and at the next off transition otherwise.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      volt_limit_dac <= 16'h0000;
      curr_limit_dac <= 16'h0000;
    end else if (!output_on) begin
      volt_limit_dac <= off_limit(off_limit_select[`OSCC_SEL_VMAX], off_limit_select[`OSCC_SEL_VPRG],
                                  off_state_limit_value_v);
      curr_limit_dac <= off_limit(off_limit_select[`OSCC_SEL_IMAX], off_limit_select[`OSCC_SEL_IPRG],
                                  off_state_limit_value_i);
    end else begin
      volt_limit_dac <= volt_mode ? MAX_LIMIT : volt_setpoint;
      curr_limit_dac <= volt_mode ? curr_setpoint : MAX_LIMIT;
    end
  end

  // Questionable bits and device error; a status clear loses to a new event.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      questionable <= 4'h0;
      device_error <= 1'b0;
    end else begin
      questionable <= ((cmd == `OSCC_CMD_DCLR) ? 4'h0 : questionable)
                      | {curr_hard, lim_s2 & output_on, out_window, 1'b0};
      device_error <= ((cmd == `OSCC_CMD_DCLR) ? 1'b0 : device_error) | err_any;
    end
  end

  // Reply generator for empty reads and received strings.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      obuf_full <= 1'b0;
    end else begin
      tx_valid <= 1'b0;
      if (dp_write && hit(dp_addr, `OSCC_REG_STATUS)) begin
        obuf_full <= hwdata[0];
      end
      if (cmd == `OSCC_CMD_READ && flags[`OSCC_FLG_LF] && !obuf_full) begin
        tx_valid <= 1'b1;
        tx_data <= `OSCC_LINEFEED;
      end else if (cmd == `OSCC_CMD_STRING && !flags[`OSCC_FLG_LF]) begin
        tx_valid <= 1'b1;
        tx_data <= `OSCC_LINEFEED;
      end
    end
  end

  // Read data mux; unmapped addresses read zero.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
    end else if (ap_valid && !hwrite) begin
      case ({haddr[11:2], 2'b00})
        `OSCC_REG_CTRL: hrdata <= {31'h00000000, volt_mode};
        `OSCC_REG_OFFSEL: hrdata <= {28'h0000000, off_limit_select};
        `OSCC_REG_OFFVAL: hrdata <= {off_state_limit_value_i, off_state_limit_value_v};
        `OSCC_REG_WINDOW: hrdata <= {16'h0000, tolerance_window_setting};
        `OSCC_REG_ERRCFG: hrdata <= {24'h000000, error_response_config};
        `OSCC_REG_FLAGS: hrdata <= {29'h00000000, flags};
        `OSCC_REG_STATUS: hrdata <= {24'h000000, obuf_full, device_error, output_on, 1'b0, questionable};
        `OSCC_REG_MEAS: hrdata <= {curr_s2, meas_s2};
        `OSCC_REG_SETPT: hrdata <= {curr_setpoint, volt_setpoint};
        `OSCC_REG_NVM_WIN: hrdata <= {16'h0000, nvm_window};
        `OSCC_REG_NVM_IF: hrdata <= nvm_iface;
        `OSCC_REG_SYSSET: hrdata <= {staged_sysset, system_settings_cmd};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

endmodule // oscc_top

// >>> include/oscc_defines.vh
// Constants for the output state and configuration controller.
// Assumes a 200 MHz sys_clk and an AHB-Lite register bus with 32-bit words.
`ifndef OSCC_DEFINES_VH
`define OSCC_DEFINES_VH
// Register byte offsets.
`define OSCC_REG_CTRL 12'h000
`define OSCC_REG_OFFSEL 12'h004
`define OSCC_REG_OFFVAL 12'h008
`define OSCC_REG_WINDOW 12'h00c
`define OSCC_REG_ERRCFG 12'h010
`define OSCC_REG_FLAGS 12'h014
`define OSCC_REG_CMD 12'h018
`define OSCC_REG_STATUS 12'h01c
`define OSCC_REG_MEAS 12'h020
`define OSCC_REG_SETPT 12'h024
`define OSCC_REG_NVM_WIN 12'h028
`define OSCC_REG_NVM_IF 12'h02c
`define OSCC_REG_SYSSET 12'h030
// Command codes written to the command register.
`define OSCC_CMD_NONE 4'h0
`define OSCC_CMD_RST 4'h1
`define OSCC_CMD_DCLR 4'h2
`define OSCC_CMD_OUT_ON 4'h3
`define OSCC_CMD_OUT_OFF 4'h4
`define OSCC_CMD_UPD_SHUT 4'h5
`define OSCC_CMD_UPD_IF 4'h6
`define OSCC_CMD_FACTORY 4'h7
`define OSCC_CMD_STAGE 4'h8
`define OSCC_CMD_STRING 4'h9
`define OSCC_CMD_READ 4'ha
// Field positions in the flag word.
`define OSCC_FLG_LF 0
`define OSCC_FLG_DC 1
`define OSCC_FLG_RO 2
// Off-limit selection bits.
`define OSCC_SEL_VMAX 0
`define OSCC_SEL_IMAX 1
`define OSCC_SEL_VPRG 2
`define OSCC_SEL_IPRG 3
// Error configuration bits.
`define OSCC_ERR_WIN 0
`define OSCC_ERR_LIM 1
`define OSCC_ERR_HARD 2
`define OSCC_ERR_SHUT 3
// Reset and factory values, and the reply byte.
`define OSCC_WINDOW_DEFAULT 16'h0020
`define OSCC_SEL_DEFAULT 4'h0
`define OSCC_FLAGS_DEFAULT 3'h0
`define OSCC_LINEFEED 8'h0a
// Maximum limit is 110 percent of the 16-bit full-scale rating, saturated at 16'hffff.
`define OSCC_PCT_MAX 110
`define OSCC_PCT_BASE 100
`endif

// >>> verification/oscc_host.sv
// Host model: a single AHB-Lite master doing whole-word single transfers.
// Assumes the slave's hreadyout is the bus hready.
`timescale 1ns/1ps
module oscc_host (
  input wire sys_clk,
  input wire hreadyout,
  input wire [31:0] hrdata,
  output reg hsel = 1'b0,
  output reg [11:0] haddr = 12'h000,
  output reg [1:0] htrans = 2'b00,
  output reg hwrite = 1'b0,
  output reg [2:0] hsize = 3'h2,
  output reg [31:0] hwdata = 32'h0,
  output reg [31:0] rd_q = 32'h0,
  output reg [15:0] rd_cnt = 16'h0
);
  // One transfer; released address and data show the inverse so stale values never pass.
  task xfer(input [11:0] a, input w, input [31:0] d);
    begin
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) @(posedge sys_clk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      haddr <= ~a;
      hwdata <= d;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) @(posedge sys_clk);
      hwdata <= ~d;
      if (!w) begin
        rd_q <= hrdata;
        rd_cnt <= rd_cnt + 16'h1;
      end
    end
  endtask
endmodule // oscc_host

// >>> verification/oscc_top_sva.sv
// Checker for the output state controller, watching only the top ports.
// Assumes hready is tied to hreadyout and a single host on the register bus.
`timescale 1ns/1ps
`include "oscc_defines.vh"
module oscc_chk (
  input wire sys_clk,
  input wire rst_n,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire output_on,
  input wire volt_mode,
  input wire [15:0] volt_setpoint,
  input wire [15:0] curr_setpoint,
  input wire [15:0] volt_limit_dac,
  input wire [15:0] curr_limit_dac,
  input wire status_clear,
  input wire tx_valid,
  input wire [7:0] tx_data
);
  reg wv; // A write is in its data phase.
  reg [11:0] wa; // Address of that write.
  reg [3:0] sel; // Host copy of the off-limit selection.
  reg [2:0] flg; // Host copy of the flag word.
  wire wc = wv && wa == `OSCC_REG_CMD;
  wire [3:0] cd = hwdata[3:0];
  // Shadow what the host wrote, so the rules can be judged from the bus alone.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wv <= 1'b0;
      wa <= 12'h000;
      sel <= 4'h0;
      flg <= 3'h0;
    end else begin
      if (hready) begin
        wv <= hsel && htrans[1] && hwrite;
        wa <= haddr;
      end
      if (wv && wa == `OSCC_REG_OFFSEL) begin
        sel <= hwdata[3:0];
      end
      if (wv && wa == `OSCC_REG_FLAGS) begin
        flg <= hwdata[2:0];
      end
      // Factory restore wipes both copies.
      if (wc && cd == `OSCC_CMD_FACTORY) begin
        sel <= 4'h0;
        flg <= 3'h0;
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_ans; hreadyout && !hresp; endproperty
  property p_lf; tx_valid |-> tx_data == `OSCC_LINEFEED; endproperty
  property p_txp; tx_valid |=> !tx_valid; endproperty
  property p_str; wc && cd == `OSCC_CMD_STRING && !flg[0] |-> ##2 tx_valid; endproperty
  property p_on; wc && cd == `OSCC_CMD_OUT_ON |-> ##2 output_on; endproperty
  property p_off; wc && cd == `OSCC_CMD_OUT_OFF |-> ##2 !output_on; endproperty
  property p_rst;
    wc && cd == `OSCC_CMD_RST |-> ##2 output_on == flg[2] && volt_mode && volt_setpoint == 16'h0000;
  endproperty
  property p_dc1; wc && cd == `OSCC_CMD_DCLR && flg[1] |-> ##2 output_on == flg[2]; endproperty
  property p_dc0; wc && cd == `OSCC_CMD_DCLR && !flg[1] |-> ##2 output_on == $past(output_on, 2); endproperty
  property p_clr; wc && cd == `OSCC_CMD_DCLR |-> ##[1:2] status_clear; endproperty
  property p_zero;
    (!output_on && sel == 4'h0) [*3] |-> volt_limit_dac == 16'h0000 && curr_limit_dac == 16'h0000;
  endproperty
  a_ans: assert property (p_ans) else $error("bus answer not ready and okay");
  a_lf: assert property (p_lf) else $error("transmitted byte is not a line feed");
  a_txp: assert property (p_txp) else $error("transmit strobe too long");
  a_str: assert property (p_str) else $error("no reply to a string");
  a_on: assert property (p_on) else $error("output did not switch on");
  a_off: assert property (p_off) else $error("output did not switch off");
  a_rst: assert property (p_rst) else $error("reset command state wrong");
  a_dc1: assert property (p_dc1) else $error("clear did not act as reset");
  a_dc0: assert property (p_dc0) else $error("clear altered the output");
  a_clr: assert property (p_clr) else $error("no status clear pulse");
  a_zero: assert property (p_zero) else $error("off limits not zero");
  c_tx: cover property (tx_valid);
  c_clr: cover property (status_clear);
  c_on: cover property ($rose(output_on));
endmodule // oscc_chk
bind oscc_top oscc_chk oscc_chk_i (.sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hreadyout, .hresp, .output_on, .volt_mode, .volt_setpoint, .curr_setpoint, .volt_limit_dac,
  .curr_limit_dac, .status_clear, .tx_valid, .tx_data);

// >>> verification/test_output_state_config_control.sv
// Self-checking bench for the output state controller.
// Assumes one bus host model; the watchdog bounds the whole run.
`timescale 1ns/1ps
`include "oscc_defines.vh"
module test_output_state_config_control;
  localparam [15:0] RFS = 16'h8000; // Rating chosen so the maximum is not saturated.
  localparam [31:0] MAXW = RFS * `OSCC_PCT_MAX / `OSCC_PCT_BASE;
  localparam [15:0] MAXV = MAXW[15:0];
  localparam [23:0] SELS = 24'h0c8421; // Selections, never a maximum with its programmed twin.
  reg sys_clk = 1'b0;
  reg rst_n = 1'b0;
  reg [15:0] meas_main = 16'h0;
  reg [15:0] meas_curr = 16'h0;
  reg at_curr_limit = 1'b0;
  wire hsel, hwrite, hreadyout, hresp, output_on, volt_mode, device_error, status_clear, tx_valid;
  wire [11:0] haddr;
  wire [1:0] htrans;
  wire [2:0] hsize;
  wire [31:0] hwdata, hrdata, rd_q;
  wire [15:0] volt_setpoint, curr_setpoint, volt_limit_dac, curr_limit_dac, rd_cnt;
  wire [3:0] questionable;
  wire [7:0] tx_data;
  integer num_errors = 0;
  integer cmp_count = 0;
  integer seed = 18995;
  integer clr_n = 0;
  integer i;
  reg [31:0] rq[$]; // Expected read data, oldest first.
  reg [7:0] tq[$]; // Expected transmitted bytes.
  reg [31:0] ov;
  reg [3:0] s;
  reg [15:0] ev, ei;
  always #2.5 sys_clk = ~sys_clk;
  oscc_top #(.RATED_FS(RFS)) oscc_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .meas_main(meas_main), .meas_curr(meas_curr),
    .at_curr_limit(at_curr_limit), .output_on(output_on), .volt_mode(volt_mode),
    .volt_setpoint(volt_setpoint), .curr_setpoint(curr_setpoint), .volt_limit_dac(volt_limit_dac),
    .curr_limit_dac(curr_limit_dac), .questionable(questionable), .device_error(device_error),
    .status_clear(status_clear), .tx_valid(tx_valid), .tx_data(tx_data));
  oscc_host oscc_host_i (.sys_clk(sys_clk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .rd_q(rd_q),
    .rd_cnt(rd_cnt));
  task note(input ok, input [31:0] w);
    begin
      cmp_count = cmp_count + 1;
      if (!ok) begin
        num_errors = num_errors + 1;
        $display("Error at %0t: %0s mismatch", $time, w);
      end
    end
  endtask
  task chk_rd(input [31:0] g, input [31:0] e); note(g === e, "read"); endtask
  task chk_pin(input [15:0] g, input [15:0] e); note(g === e, "pin"); endtask
  task chk_tx(input [7:0] g, input [7:0] e); note(g === e, "tx"); endtask
  task wr(input [11:0] a, input [31:0] d); oscc_host_i.xfer(a, 1'b1, d); endtask
  task rd(input [11:0] a, input [31:0] e);
    begin
      rq.push_back(e);
      oscc_host_i.xfer(a, 1'b0, 32'h0);
    end
  endtask
  // A command acts one cycle after its data phase, and its pulses are taken at the edge after
  // that; look only once both have happened, so the counters and queues are up to date.
  task cmd(input [3:0] c);
    begin
      wr(`OSCC_REG_CMD, {28'h0, c});
      repeat (3) @(negedge sys_clk);
    end
  endtask
  task final_report;
    begin
      if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // Each finished read is compared with the oldest expectation.
  always @(rd_cnt) chk_rd(rd_q, rq.pop_front());
  // Transmitted bytes and clear pulses are caught at the edge they stand in.
  always @(posedge sys_clk) begin
    if (tx_valid === 1'b1) chk_tx(tx_data, tq.pop_front());
    if (status_clear === 1'b1) clr_n = clr_n + 1;
  end
  initial begin
    #100000;
    num_errors = num_errors + 1;
    final_report;
  end
  initial begin
    ov = $random(seed);
    meas_curr <= {4'h0, ov[11:0]};
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rd(`OSCC_REG_WINDOW, 32'h20);
    rd(`OSCC_REG_OFFSEL, 32'h0);
    rd(12'h0fc, 32'h0);
    for (i = 0; i < 6; i = i + 1) begin
      s = SELS[i*4 +: 4];
      ov = $random(seed);
      wr(`OSCC_REG_OFFVAL, ov);
      wr(`OSCC_REG_OFFSEL, {28'h0, s});
      repeat (2) @(negedge sys_clk);
      ev = s[0] ? MAXV : (s[2] ? ov[15:0] : 16'h0);
      ei = s[1] ? MAXV : (s[3] ? ov[31:16] : 16'h0);
      chk_pin(volt_limit_dac, ev);
      chk_pin(curr_limit_dac, ei);
    end
    wr(`OSCC_REG_WINDOW, 32'h55);
    cmd(`OSCC_CMD_UPD_IF);
    rd(`OSCC_REG_NVM_WIN, 32'h20);
    cmd(`OSCC_CMD_UPD_SHUT);
    rd(`OSCC_REG_NVM_WIN, 32'h55);
    rd(`OSCC_REG_WINDOW, 32'h55);
    wr(`OSCC_REG_SETPT, 32'h02000100);
    cmd(`OSCC_CMD_RST);
    chk_pin({15'h0, output_on}, 16'h0);
    chk_pin(volt_setpoint, 16'h0);
    chk_pin({15'h0, volt_mode}, 16'h1);
    wr(`OSCC_REG_FLAGS, 32'h4);
    cmd(`OSCC_CMD_RST);
    chk_pin({15'h0, output_on}, 16'h1);
    wr(`OSCC_REG_SETPT, 32'h02000100);
    repeat (2) @(negedge sys_clk);
    chk_pin(volt_setpoint, 16'h0100);
    cmd(`OSCC_CMD_OUT_OFF);
    chk_pin({15'h0, output_on}, 16'h0);
    cmd(`OSCC_CMD_OUT_ON);
    chk_pin({15'h0, output_on}, 16'h1);
    wr(`OSCC_REG_FLAGS, 32'h0);
    cmd(`OSCC_CMD_DCLR);
    chk_pin({15'h0, output_on}, 16'h1);
    chk_pin(clr_n[15:0], 16'h1);
    wr(`OSCC_REG_FLAGS, 32'h2);
    cmd(`OSCC_CMD_DCLR);
    chk_pin({15'h0, output_on}, 16'h0);
    chk_pin(curr_setpoint, 16'h0);
    // Replies: one expected per note; any reply with no note pops an empty queue and fails.
    wr(`OSCC_REG_FLAGS, 32'h0);
    tq.push_back(`OSCC_LINEFEED);
    cmd(`OSCC_CMD_STRING);
    wr(`OSCC_REG_FLAGS, 32'h1);
    cmd(`OSCC_CMD_STRING);
    wr(`OSCC_REG_STATUS, 32'h0);
    tq.push_back(`OSCC_LINEFEED);
    cmd(`OSCC_CMD_READ);
    wr(`OSCC_REG_STATUS, 32'h1);
    cmd(`OSCC_CMD_READ);
    chk_pin(16'(tq.size()), 16'h0);
    wr(`OSCC_REG_SYSSET, 32'h00001234);
    cmd(`OSCC_CMD_STAGE);
    rd(`OSCC_REG_SYSSET, 32'h12341234);
    wr(`OSCC_REG_OFFSEL, 32'h4);
    cmd(`OSCC_CMD_FACTORY);
    rd(`OSCC_REG_OFFSEL, 32'h0);
    rd(`OSCC_REG_FLAGS, 32'h0);
    rd(`OSCC_REG_WINDOW, 32'h20);
    rd(`OSCC_REG_SYSSET, 32'h0);
    // Settle the measurement on the setpoint before the output goes on, then clear the
    // sticky bits left by earlier scenarios, so only the later excursion can set them.
    meas_main <= 16'h1000;
    wr(`OSCC_REG_SETPT, 32'h00001000);
    cmd(`OSCC_CMD_OUT_ON);
    cmd(`OSCC_CMD_DCLR);
    chk_pin({15'h0, questionable[1]}, 16'h0);
    chk_pin({15'h0, device_error}, 16'h0);
    chk_pin({15'h0, output_on}, 16'h1);
    wr(`OSCC_REG_ERRCFG, 32'h9);
    meas_main <= 16'h1100;
    repeat (8) @(negedge sys_clk);
    chk_pin({15'h0, questionable[1]}, 16'h1);
    chk_pin({15'h0, device_error}, 16'h1);
    chk_pin({15'h0, output_on}, 16'h0);
    final_report;
  end
endmodule // test_output_state_config_control
